/* inc/bsx_pkg.sv */
// constants for the block store decode, check and execute unit
package bsx_pkg;
  localparam logic [1:0] OP_MEM = 2'h3;
  localparam logic [5:0] OP3_ALT_DFP_ST = 6'h37;
  localparam logic [7:0] ID_BLK_USER_P = 8'h16;
  localparam logic [7:0] ID_BLK_USER_S = 8'h17;
  localparam logic [7:0] ID_BLK_USER_PL = 8'h1e;
  localparam logic [7:0] ID_BLK_USER_SL = 8'h1f;
  localparam logic [7:0] ID_BLK_P = 8'hf0;
  localparam logic [7:0] ID_BLK_S = 8'hf1;
  localparam logic [7:0] ID_BLK_PL = 8'hf8;
  localparam logic [7:0] ID_BLK_SL = 8'hf9;
  localparam int ID_PRIV_BIT = 7;
  localparam int BLK_ALIGN_BITS = 6;
  localparam int DW_ALIGN_BITS = 3;
  localparam int NUM_DW = 8;
  localparam int FIFO_DEPTH = 32;
  // bus register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WATCH_LO = 8'h04;
  localparam logic [7:0] REG_WATCH_HI = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_COUNT = 8'h10;
  // control fields
  localparam int CTRL_WATCH_EN = 0;
  localparam int CTRL_WATCH_FIRST8 = 1;
  localparam int CTRL_NC_STRICT = 2;
  localparam int CTRL_FPU_PRESENT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h8;
  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_TRAP_LSB = 4;
  // trap codes
  localparam logic [2:0] TRAP_NONE = 3'h0;
  localparam logic [2:0] TRAP_ILLEGAL = 3'h1;
  localparam logic [2:0] TRAP_FP_OFF = 3'h2;
  localparam logic [2:0] TRAP_PRIV = 3'h3;
  localparam logic [2:0] TRAP_ALIGN = 3'h4;
  localparam logic [2:0] TRAP_WATCH = 3'h5;
  typedef enum logic [2:0] {ST_IDLE, ST_DRAIN, ST_RDREQ, ST_WAIT, ST_PUSH} bsx_state_t;
endpackage

/* rtl/bsx_block_store.sv */
// block store decode, trap check and doubleword write sequencer
`timescale 1ns/1ps
module bsx_block_store #(
  parameter int AW = 64,
  parameter int FIFO_DEPTH = bsx_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic issue_valid_i,
  output logic issue_ready_o,
  input wire logic [31:0] insn_i,
  input wire logic [7:0] asi_reg_i,
  input wire logic [AW-1:0] ea_i,
  input wire logic priv_mode_bit_i,
  input wire logic hyper_mode_bit_i,
  input wire logic fp_enable_bit_i,
  input wire logic fp_unit_enable_bit_i,
  input wire logic page_cacheable_bit_i,
  output logic fpr_rd_en_o,
  output logic [5:0] fpr_rd_idx_o,
  input wire logic [63:0] fpr_rd_data_i,
  output logic mem_valid_o,
  input wire logic mem_ready_i,
  output logic [AW-1:0] mem_addr_o,
  output logic [63:0] mem_data_o,
  output logic trap_valid_o,
  output logic [2:0] trap_code_o,
  output logic done_o,
  output logic other_op_o
);
  import bsx_pkg::*;

  function automatic logic [63:0] swap64(input logic [63:0] d);
    logic [63:0] r;
    r = '0;
    for (int b = 0; b < 8; b++) begin
      r[8*b +: 8] = d[8*(7-b) +: 8];
    end
    return r;
  endfunction

  // the opcode is shared with the other fp alternate stores, so only these ids select us
  function automatic logic is_block_id(input logic [7:0] id);
    return id == ID_BLK_USER_P
        || id == ID_BLK_USER_S
        || id == ID_BLK_USER_PL
        || id == ID_BLK_USER_SL
        || id == ID_BLK_P
        || id == ID_BLK_S
        || id == ID_BLK_PL
        || id == ID_BLK_SL;
  endfunction

  function automatic logic is_le_id(input logic [7:0] id);
    return id == ID_BLK_USER_PL
        || id == ID_BLK_USER_SL
        || id == ID_BLK_PL
        || id == ID_BLK_SL;
  endfunction

  // instruction fields
  wire [1:0] op_fld = insn_i[31:30];
  wire [4:0] rd_fld = insn_i[29:25];
  wire [5:0] opcode_sub_field = insn_i[24:19];
  wire imm_sel = insn_i[13];
  wire [7:0] imm_id = insn_i[12:5];
  // double register number: rd bit 0 is the high bit
  wire [5:0] base_dreg = {rd_fld[0], rd_fld[4:1], 1'b0};

  // registers reached over the bus
  logic [3:0] ctrl_r;
  logic [AW-1:0] watch_r;
  logic [31:0] count_r;
  logic [2:0] last_trap_r;

  // sequencer state
  bsx_state_t state_r;
  bsx_state_t state_nxt;
  logic [AW-1:0] ea_r;
  logic [5:0] base_r;
  logic le_r;
  logic [2:0] dw_r;
  logic [63:0] data_r;

  wire take = issue_valid_i && issue_ready_o;
  wire opc_hit = (op_fld == OP_MEM) && (opcode_sub_field == OP3_ALT_DFP_ST);
  wire [7:0] eff_id = imm_sel ? asi_reg_i : imm_id;
  wire blk_hit = opc_hit && is_block_id(eff_id);
  wire blk_le = is_le_id(eff_id);

  // trap checks, in priority order
  wire t_illegal = base_dreg[3:0] != 4'h0;
  wire t_fp_off = !fp_enable_bit_i || !fp_unit_enable_bit_i
               || !ctrl_r[CTRL_FPU_PRESENT];
  wire user_mode = !priv_mode_bit_i && !hyper_mode_bit_i;
  wire t_priv = user_mode && !eff_id[ID_PRIV_BIT];
  wire t_align = ea_i[BLK_ALIGN_BITS-1:0] != '0;
  // non-cacheable page traps unless strict ordering is selected
  wire t_nc = !page_cacheable_bit_i && !ctrl_r[CTRL_NC_STRICT];
  // full mode matches any doubleword of the block, reduced mode the first one only
  wire watch_blk = ea_i[AW-1:BLK_ALIGN_BITS] == watch_r[AW-1:BLK_ALIGN_BITS];
  wire watch_dw0 = watch_r[BLK_ALIGN_BITS-1:DW_ALIGN_BITS] == '0;
  wire t_watch = ctrl_r[CTRL_WATCH_EN] && watch_blk
              && (!ctrl_r[CTRL_WATCH_FIRST8] || watch_dw0);

  logic [2:0] trap_sel;
  always_comb begin
    if (t_illegal) begin
      trap_sel = TRAP_ILLEGAL;
    end else if (t_fp_off) begin
      trap_sel = TRAP_FP_OFF;
    end else if (t_priv) begin
      trap_sel = TRAP_PRIV;
    end else if (t_align) begin
      trap_sel = TRAP_ALIGN;
    end else if (t_nc) begin
      trap_sel = TRAP_ILLEGAL;
    end else if (t_watch) begin
      trap_sel = TRAP_WATCH;
    end else begin
      trap_sel = TRAP_NONE;
    end
  end

  wire blk_trap = take && blk_hit && (trap_sel != TRAP_NONE);
  wire blk_go = take && blk_hit && (trap_sel == TRAP_NONE);
  // strict order: wait for every earlier write to leave before starting
  wire need_drain = !page_cacheable_bit_i;

  // fifo carries address and data of each doubleword
  logic fifo_in_ready;
  logic fifo_empty;
  wire fifo_push = state_r == ST_PUSH;
  wire last_dw = dw_r == 3'(NUM_DW - 1);
  // a doubleword leaves the sequencer only when the fifo takes it
  wire dw_accept = fifo_push && fifo_in_ready;
  // one aligned 64-bit write per doubleword, so a watcher sees old or new, never a mix
  wire [AW-1:0] dw_addr = {ea_r[AW-1:BLK_ALIGN_BITS], dw_r, 3'h0};

  bsx_fifo #(
    .WIDTH(AW + 64),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({dw_addr, data_r}),
    .out_valid_o(mem_valid_o),
    .out_ready_i(mem_ready_i),
    .out_data_o({mem_addr_o, mem_data_o}),
    .empty_o(fifo_empty)
  );

  // the fifo lets later instructions run while writes drain, which is why
  // ordering against later loads and stores is left to barriers in software
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (blk_go) begin
          state_nxt = need_drain ? ST_DRAIN : ST_RDREQ;
        end
      end
      ST_DRAIN: begin
        if (fifo_empty) begin
          state_nxt = ST_RDREQ;
        end
      end
      ST_RDREQ: begin
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        state_nxt = ST_PUSH;
      end
      ST_PUSH: begin
        if (fifo_in_ready) begin
          state_nxt = last_dw ? ST_IDLE : ST_RDREQ;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      issue_ready_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      issue_ready_o <= state_nxt == ST_IDLE;
    end
  end

  // latch the accepted block store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ea_r <= '0;
      base_r <= '0;
      le_r <= 1'b0;
    end else if (blk_go) begin
      ea_r <= ea_i;
      base_r <= base_dreg;
      le_r <= blk_le;
    end
  end

  function automatic logic [2:0] dw_nxt_idx();
    return dw_accept ? dw_r + 3'h1 : dw_r;
  endfunction

  // base_r loads at the same edge as the first read unless a drain comes first, so that read takes the
  // decoded field itself; later reads step the index by two, one double register
  wire [5:0] rd_idx_nxt = blk_go ? base_dreg : base_r + {2'h0, dw_nxt_idx(), 1'b0};

  // register reads go straight to the file without interlocking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fpr_rd_en_o <= 1'b0;
      fpr_rd_idx_o <= '0;
    end else begin
      fpr_rd_en_o <= state_nxt == ST_RDREQ;
      fpr_rd_idx_o <= rd_idx_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dw_r <= '0;
      data_r <= '0;
    end else begin
      if (blk_go) begin
        dw_r <= '0;
      end else if (fifo_push && fifo_in_ready) begin
        dw_r <= dw_r + 3'h1;
      end
      // read data stands one cycle only, so it is caught in the wait state
      if (state_r == ST_WAIT) begin
        data_r <= le_r ? swap64(fpr_rd_data_i) : fpr_rd_data_i;
      end
    end
  end

  // event outputs; a trapped store never reaches the fifo
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_valid_o <= 1'b0;
      trap_code_o <= TRAP_NONE;
      done_o <= 1'b0;
      other_op_o <= 1'b0;
      last_trap_r <= TRAP_NONE;
    end else begin
      trap_valid_o <= blk_trap;
      trap_code_o <= blk_trap ? trap_sel : TRAP_NONE;
      done_o <= fifo_push && fifo_in_ready && last_dw;
      other_op_o <= take && !blk_hit;
      if (blk_trap) begin
        last_trap_r <= trap_sel;
      end
    end
  end

  // wishbone slave, one wait state, unmapped reads return zero
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // a write lands at the edge where the master sees ack, while it still holds the request
  wire wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  wire hit_ctrl = wb_adr_i == REG_CTRL;
  wire hit_wlo = wb_adr_i == REG_WATCH_LO;
  wire hit_whi = wb_adr_i == REG_WATCH_HI;
  wire hit_stat = wb_adr_i == REG_STATUS;
  wire hit_cnt = wb_adr_i == REG_COUNT;
  wire wr_ctrl = wb_wr && hit_ctrl;
  wire wr_wlo = wb_wr && hit_wlo;
  wire wr_whi = wb_wr && hit_whi;
  wire wr_cnt = wb_wr && hit_cnt;
  wire busy = state_r != ST_IDLE || !fifo_empty;
  wire [31:0] stat_word = {25'h0, last_trap_r, 3'h0, busy};
  wire [31:0] wb_rd_mux = hit_ctrl ? {28'h0, ctrl_r}
                        : hit_wlo ? watch_r[31:0]
                        : hit_whi ? watch_r[AW-1:32]
                        : hit_stat ? stat_word
                        : hit_cnt ? count_r : 32'h0;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  wire [31:0] ctrl_nxt = merge({28'h0, ctrl_r}, wb_dat_i, wb_sel_i);
  wire [31:0] wlo_nxt = merge(watch_r[31:0], wb_dat_i, wb_sel_i);
  wire [31:0] whi_nxt = merge(watch_r[AW-1:32], wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req && !wb_we_i ? wb_rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RESET;
      watch_r <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= ctrl_nxt[3:0];
      end
      if (wr_wlo) begin
        watch_r[31:0] <= wlo_nxt;
      end
      if (wr_whi) begin
        watch_r[AW-1:32] <= whi_nxt;
      end
    end
  end

  // completed block stores; a write of any value clears, a completion in the same cycle leaves 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= '0;
    end else if (dw_accept && last_dw) begin
      count_r <= wr_cnt ? 32'h1 : count_r + 32'h1;
    end else if (wr_cnt) begin
      count_r <= '0;
    end
  end
endmodule

/* rtl/bsx_fifo.sv */
// store fifo with registered output stage
`timescale 1ns/1ps
module bsx_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic empty_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire push = in_valid_i && in_ready_o;
  wire load = (count_r != '0) && (!out_valid_o || out_ready_i);
  assign in_ready_o = count_r != (AW+1)'(DEPTH);
  assign empty_o = (count_r == '0) && !out_valid_o;
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (load) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
        out_data_o <= mem_r[rd_ptr_r];
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(load);
    end
  end
endmodule

/* verif/bsx_block_store_assertions.sv */
// port assertions for the block store unit
`timescale 1ns/1ps
module bsx_block_store_assertions
  import bsx_pkg::*;
#(parameter int AW = 64) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic issue_valid_i,
  input wire logic issue_ready_o,
  input wire logic [31:0] insn_i,
  input wire logic [7:0] asi_reg_i,
  input wire logic [AW-1:0] ea_i,
  input wire logic [AW-1:0] mem_addr_o,
  input wire logic priv_mode_bit_i,
  input wire logic hyper_mode_bit_i,
  input wire logic fp_enable_bit_i,
  input wire logic fp_unit_enable_bit_i,
  input wire logic page_cacheable_bit_i,
  input wire logic fpr_rd_en_o,
  input wire logic [5:0] fpr_rd_idx_o,
  input wire logic mem_valid_o,
  input wire logic mem_ready_i,
  input wire logic trap_valid_o,
  input wire logic other_op_o,
  input wire logic [63:0] mem_data_o,
  input wire logic [2:0] trap_code_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] id;
  logic [5:0] base, last_idx;
  logic blk, take, ok1, ok2, ok3;
  assign id = insn_i[13] ? asi_reg_i : insn_i[12:5];
  assign blk = insn_i[31:30] == OP_MEM && insn_i[24:19] == OP3_ALT_DFP_ST &&
    id inside {8'h16, 8'h17, 8'h1e, 8'h1f, 8'hf0, 8'hf1, 8'hf8, 8'hf9};
  assign take = issue_valid_i && issue_ready_o;
  assign base = {insn_i[25], insn_i[29:26], 1'b0};
  // checks pass in priority order: register, fp, privilege
  assign ok1 = insn_i[28:26] == 3'h0;
  assign ok2 = ok1 && fp_enable_bit_i && fp_unit_enable_bit_i;
  assign ok3 = ok2 && (priv_mode_bit_i || hyper_mode_bit_i || id[ID_PRIV_BIT]);
  always_ff @(posedge clk_i) begin
    if (fpr_rd_en_o) last_idx <= fpr_rd_idx_o;
  end
  sequence s_blk;
    take && blk;
  endsequence
  sequence s_trap(logic [2:0] c);
    trap_valid_o && trap_code_o == c;
  endsequence
  illegal_trap_a: assert property (s_blk ##0 !ok1 |=> s_trap(TRAP_ILLEGAL))
    else $error("misaligned register not trapped");
  fp_trap_a: assert property (s_blk ##0 (ok1 && !ok2) |=> s_trap(TRAP_FP_OFF))
    else $error("fp_off_trap not trapped");
  priv_trap_a: assert property (s_blk ##0 (ok2 && !ok3) |=> s_trap(TRAP_PRIV))
    else $error("privilege not trapped");
  align_trap_a: assert property (s_blk ##0 (ok3 && ea_i[5:0] != 6'h0) |=>
    s_trap(TRAP_ALIGN)) else $error("misaligned block not trapped");
  store_start_a: assert property (s_blk ##0 (ok3 && ea_i[5:0] == 6'h0 &&
    page_cacheable_bit_i) |=> (fpr_rd_en_o && fpr_rd_idx_o == $past(base)) ||
    (trap_valid_o && trap_code_o inside {TRAP_WATCH, TRAP_FP_OFF}))
    else $error("good block store did not start");
  other_op_a: assert property (take && !blk |=> other_op_o && !trap_valid_o)
    else $error("other op not flagged");
  reg_step_a: assert property (fpr_rd_en_o && fpr_rd_idx_o[3:1] != 3'h0 |->
    fpr_rd_idx_o == last_idx + 6'h2) else $error("register order broken");
  mem_hold_a: assert property (mem_valid_o && !mem_ready_i |=>
    mem_valid_o && $stable(mem_addr_o) && $stable(mem_data_o)) else $error("write not held");
  trap_quiet_a: assert property (trap_valid_o |-> issue_ready_o && !fpr_rd_en_o)
    else $error("trapped store went on");
  dw_align_a: assert property (mem_valid_o |-> mem_addr_o[2:0] == 3'h0)
    else $error("write not doubleword aligned");
endmodule

/* verif/bsx_block_store_tb_top.sv */
// self-checking bench for the block store unit
`timescale 1ns/1ps
module bsx_block_store_tb_top;
  import bsx_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0, asi_reg_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, insn_i = 32'h0, rd_v;
  logic wb_ack_o, issue_valid_i = 1'b0, issue_ready_o, priv_mode_bit_i = 1'b0;
  logic hyper_mode_bit_i = 1'b0, fp_enable_bit_i = 1'b0, fp_unit_enable_bit_i = 1'b0;
  logic page_cacheable_bit_i = 1'b0, fpr_rd_en_o, mem_valid_o, mem_ready_i;
  logic [63:0] ea_i = 64'h0, mem_addr_o, mem_data_o, fpr_rd_data_i, ea;
  logic trap_valid_o, done_o, other_op_o;
  logic [5:0] fpr_rd_idx_o;
  logic [2:0] trap_code_o;
  logic [1:0] mode = 2'h0;
  logic [63:0] exp_a[$], exp_d[$];
  logic [4:0] rd_tab[4] = '{5'h0, 5'h10, 5'h1, 5'h11};
  logic [7:0] ids[8] = '{8'h16, 8'h17, 8'h1e, 8'h1f, 8'hf0, 8'hf1, 8'hf8, 8'hf9};
  int err_total = 0, num_checks = 0, cyc = 0, done_n = 0, n_good = 0;
  always #12.5 clk_i = ~clk_i;
  bsx_block_store u_dut (.*);
  bsx_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .fpr_rd_en_i(fpr_rd_en_o),
    .fpr_rd_idx_i(fpr_rd_idx_o), .fpr_rd_data_o(fpr_rd_data_i), .mem_valid_i(mem_valid_o),
    .mem_addr_i(mem_addr_o), .mem_data_i(mem_data_o), .mem_ready_o(mem_ready_i));
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // doubleword k of a store from double register b, as it should reach memory, byte swapped for the little-endian ids
  function automatic logic [63:0] exp_dw(input logic [5:0] b, input int k,
      input logic [7:0] id);
    logic [63:0] v;
    logic [63:0] s;
    v = {32'h0123_4567, 26'h0, b + 6'(2 * k)};
    s = {<<8{v}};
    return (id inside {8'h1e, 8'h1f, 8'hf8, 8'hf9}) ? s : v;
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    // ack and read data are taken as sampled at the edge itself
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd_v = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  // code 7 stands for an op that is not a block store
  task automatic run(input logic [4:0] rd, input logic [7:0] id, input logic [63:0] a,
      input logic [4:0] md, input logic [3:0] ctl, input logic [2:0] code);
    logic i;
    logic [5:0] b;
    logic [63:0] ex;
    i = 1'($urandom % 2);
    b = {rd[0], rd[4:1], 1'b0};
    ex = code == 3'h7 ? 64'h1 : {59'h0, code != 3'h0, code, 1'b0};
    wb(1'b1, REG_CTRL, {28'h0, ctl});
    do begin
      @(posedge clk_i);
      #1;
    end while (issue_ready_o !== 1'b1);
    @(posedge clk_i);
    issue_valid_i <= 1'b1;
    insn_i <= {2'b11, rd, 6'h37, 5'h3, i, i ? ~id : id, 5'h4};
    asi_reg_i <= i ? id : ~id;
    ea_i <= a;
    {priv_mode_bit_i, hyper_mode_bit_i, fp_enable_bit_i, fp_unit_enable_bit_i,
      page_cacheable_bit_i} <= md;
    @(posedge clk_i);
    issue_valid_i <= 1'b0;
    #1;
    chk("trap", {trap_valid_o, trap_code_o, other_op_o}, ex);
    if (code == 3'h0) begin
      n_good++;
    end
    for (int k = 0; k < 8 && code == 3'h0; k++) begin
      exp_a.push_back({a[63:6], 3'(k), 3'h0});
      exp_d.push_back(exp_dw(b, k, id));
    end
  endtask
  // wait for every write to land before looking at memory
  task automatic flush;
    repeat (20) @(posedge clk_i);
    for (int n = 0; n < 3000 && u_mem.got_a.size() < exp_a.size(); n++) @(posedge clk_i);
    repeat (20) @(posedge clk_i);
    chk("writes", u_mem.got_a.size(), exp_a.size());
    foreach (exp_a[k]) begin
      chk("addr", u_mem.got_a[k], exp_a[k]);
      chk("data", u_mem.got_d[k], exp_d[k]);
    end
    u_mem.got_a.delete();
    u_mem.got_d.delete();
    exp_a.delete();
    exp_d.delete();
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (done_o === 1'b1) begin
      done_n <= done_n + 1;
    end
    if (cyc == 20000) begin
      err_total++;
      summarize;
    end
  end
  initial begin
    rd_v = $urandom(32'h971c);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", rd_v, 32'h8);
    wb(1'b1, 8'h20, 32'hffff_ffff);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd_v, 32'h0);
    $display("test regs done");
    // memory refuses: four blocks and the first doubleword of the fifth fill the fifo, the fifth must stall
    mode <= 2'h2;
    for (int n = 0; n < 13; n++) begin
      if (n == 5) begin
        repeat (40) @(posedge clk_i);
        #1;
        chk("stalled", issue_ready_o, 1'b0);
        mode <= 2'h1;
      end
      ea = {$urandom, $urandom} & ~64'h3f;
      run(rd_tab[n % 4], ids[n % 8], ea, {ids[n % 8][7] ? 1'($urandom % 2) : 1'b1, 4'b0111},
        4'h8, 3'h0);
    end
    flush;
    $display("test stores done");
    ea = 64'h0000_1234_5678_9a40;
    wb(1'b1, REG_WATCH_LO, ea[31:0] + 32'h8);
    wb(1'b1, REG_WATCH_HI, ea[63:32]);
    run(5'h02, 8'hf0, ea, 5'b10111, 4'h8, 3'h1);
    run(5'h04, 8'hf0, ea, 5'b10001, 4'h8, 3'h1);
    run(5'h00, 8'hf0, ea, 5'b10011, 4'h8, 3'h2);
    run(5'h10, 8'hf0, ea, 5'b10101, 4'h8, 3'h2);
    run(5'h10, 8'hf0, ea, 5'b10111, 4'h0, 3'h2);
    run(5'h01, 8'h16, ea, 5'b00111, 4'h8, 3'h3);
    run(5'h01, 8'h1e, ea, 5'b01111, 4'h8, 3'h0);
    run(5'h00, 8'hf9, ea + 64'h1, 5'b10111, 4'h8, 3'h4);
    run(5'h00, 8'hf9, ea + 64'h20, 5'b00111, 4'h8, 3'h4);
    run(5'h00, 8'hf1, ea, 5'b10110, 4'h8, 3'h1);
    run(5'h00, 8'hf1, ea, 5'b10110, 4'hc, 3'h0);
    run(5'h00, 8'hf0, ea, 5'b10111, 4'h9, 3'h5);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status", rd_v[6:4], TRAP_WATCH);
    run(5'h00, 8'hf0, ea, 5'b10111, 4'hb, 3'h0);
    run(5'h00, 8'h80, ea, 5'b10111, 4'h8, 3'h7);
    flush;
    wb(1'b0, REG_COUNT, 32'h0);
    chk("count", rd_v, 32'h10);
    wb(1'b1, REG_COUNT, 32'h0);
    wb(1'b0, REG_COUNT, 32'h0);
    chk("count clear", rd_v, 32'h0);
    chk("done", done_n, n_good);
    $display("test traps done");
    summarize;
  end
endmodule
bind bsx_block_store bsx_block_store_assertions #(.AW(AW)) u_chk (.*);

/* verif/bsx_mem_model.sv */
// far side: fp register read port and memory write sink
`timescale 1ns/1ps
module bsx_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic fpr_rd_en_i,
  input wire logic [5:0] fpr_rd_idx_i,
  output logic [63:0] fpr_rd_data_o,
  input wire logic mem_valid_i,
  input wire logic [63:0] mem_addr_i,
  input wire logic [63:0] mem_data_i,
  output logic mem_ready_o
);
  logic [63:0] got_a[$];
  logic [63:0] got_d[$];
  initial begin
    fpr_rd_data_o = 64'h0;
    mem_ready_o = 1'b0;
  end
  // read data lives one cycle only, then turns to garbage
  // mode 0 always ready, 1 random stalls, 2 refuses everything
  always @(posedge clk_i) begin
    fpr_rd_data_o <= fpr_rd_en_i ? {32'h0123_4567, 26'h0, fpr_rd_idx_i} : ~fpr_rd_data_o;
    mem_ready_o <= !rst_i && (mode_i == 2'h0 || (mode_i == 2'h1 && $urandom % 2 == 1));
    if (mem_valid_i && mem_ready_o && !rst_i) begin
      got_a.push_back(mem_addr_i);
      got_d.push_back(mem_data_i);
    end
  end
endmodule
